// [core/alu_flag_datapath.sv]
// Operation
// - add source to destination, optionally with carry, update Z C N V H, one clock.
// - subtract source from destination, optionally with carry, update all five flags, one clock.
// - subtract an immediate from destination, update all five flags, one clock.
// - subtract an immediate and the carry from destination, update all five flags, one clock.
// - AND with register or immediate updates only Z N V and keeps C and H.
// - OR with register or immediate and XOR of registers update only Z N V, one clock.
// - setting mask bits ORs the immediate in and updates Z N V only.
// - clearing mask bits ANDs with the inverted immediate and updates Z N V only.
// - test ANDs a register with itself, keeps its value and updates Z N V.
// - some I/O flags clear when a one is written and stay when a zero is written.
// - bit set and clear rewrite the whole I/O register, so set write-one-clear flags get cleared.
// - bit set and clear are accepted only for I/O addresses up to hex 1F.
`timescale 1ns/1ps
`default_nettype none

module alu_flag_datapath
   import alu_flag_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic        req_valid_in,
   input  wire alu_req_type req_in,
   input  wire logic        io_wr_in,
   input  wire logic [5:0]  io_waddr_in,
   input  wire logic [7:0]  io_wdata_in,
   input  wire logic [7:0]  io_rdata_in,
   output logic [7:0]       result_out,
   output logic             result_valid_out,
   output logic [7:0]       processor_status_flags_out,
   output logic             busy_out,
   output logic             io_rd_out,
   output logic [5:0]       io_addr_out,
   output logic             io_wr_out,
   output logic [7:0]       io_wdata_out,
   output logic             bit_op_refused_out
);

   // ****************************************************************
   // state
   // ****************************************************************
   logic [7:0]    result_reg, result_next;
   logic          result_valid_reg, result_valid_next;
   logic [7:0]    flags_reg, flags_next;
   rmw_state_type state_reg, state_next;
   logic          busy_reg, busy_next;
   logic          io_rd_reg, io_rd_next;
   logic [5:0]    io_addr_reg, io_addr_next;
   logic [2:0]    bit_reg, bit_next;
   logic          set_reg, set_next;
   logic          io_wr_reg, io_wr_next;
   logic [7:0]    io_wdata_reg, io_wdata_next;
   logic          refused_reg, refused_next;

   logic          take;
   logic          is_bit_op;
   logic          sfr_wr;
   logic [7:0]    opa, opb, res, calc, upd, base;
   logic          cin, is_sub, is_arith, write_res;
   logic [8:0]    raw;

   // requests are taken only while no read-modify-write is pending
   assign take      = req_valid_in & ~busy_reg;
   assign is_bit_op = (req_in.op == io_bit_set_op) | (req_in.op == io_bit_clear_op);
   assign sfr_wr    = io_wr_in & (io_waddr_in == STATUS_FLAGS_ADDR);

   // ****************************************************************
   // operand selection and result
   // ****************************************************************
   always_comb
   begin
      opa       = req_in.dest;
      opb       = req_in.src;
      cin       = 1'b0;
      is_sub    = 1'b0;
      is_arith  = 1'b1;
      write_res = 1'b1;
      res       = 8'h00;
      upd       = 8'h00;
      calc      = 8'h00;
      case (req_in.op)
         add_op : ;
         add_carry_op :
            cin = flags_reg[FLAG_C];
         subtract_op :
            is_sub = 1'b1;
         subtract_with_carry_op :
         begin
            is_sub = 1'b1;
            cin    = flags_reg[FLAG_C];
         end
         subtract_immediate_op :
         begin
            is_sub = 1'b1;
            opb    = req_in.imm;
         end
         subtract_carry_immediate_op :
         begin
            is_sub = 1'b1;
            opb    = req_in.imm;
            cin    = flags_reg[FLAG_C];
         end
         twos_complement_op :
         begin
            is_sub = 1'b1;
            opa    = 8'h00;
            opb    = req_in.dest;
         end
         increment_op :
            opb = 8'h01;
         decrement_op :
         begin
            is_sub = 1'b1;
            opb    = 8'h01;
         end
         default :
            is_arith = 1'b0;
      endcase
      raw = is_sub ? ({1'b0, opa} - {1'b0, opb} - {8'h00, cin})
                   : ({1'b0, opa} + {1'b0, opb} + {8'h00, cin});
      if (is_arith)
      begin
         res = raw[7:0];
         // carry and half carry from the bit equations; works for both directions
         if (is_sub)
         begin
            calc[FLAG_H] = (~opa[3] & opb[3]) | (opb[3] & res[3]) | (res[3] & ~opa[3]);
            calc[FLAG_C] = (~opa[7] & opb[7]) | (opb[7] & res[7]) | (res[7] & ~opa[7]);
            calc[FLAG_V] = (opa[7] & ~opb[7] & ~res[7]) | (~opa[7] & opb[7] & res[7]);
         end
         else
         begin
            calc[FLAG_H] = (opa[3] & opb[3]) | (opb[3] & ~res[3]) | (~res[3] & opa[3]);
            calc[FLAG_C] = (opa[7] & opb[7]) | (opb[7] & ~res[7]) | (~res[7] & opa[7]);
            calc[FLAG_V] = (opa[7] & opb[7] & ~res[7]) | (~opa[7] & ~opb[7] & res[7]);
         end
         upd = 8'h3f;
         // step ops keep carry and half carry
         if ((req_in.op == increment_op) | (req_in.op == decrement_op))
            upd = 8'h1e;
      end
      else
      begin
         upd = 8'h1e;
         case (req_in.op)
            and_op               : res = req_in.dest & req_in.src;
            and_immediate_op     : res = req_in.dest & req_in.imm;
            or_op                : res = req_in.dest | req_in.src;
            or_immediate_op      : res = req_in.dest | req_in.imm;
            exclusive_or_op      : res = req_in.dest ^ req_in.src;
            set_mask_bits_op     : res = req_in.dest | req_in.imm;
            clear_mask_bits_op   : res = req_in.dest & (ALL_ONES - req_in.imm);
            zero_minus_test_op   : res = req_in.dest & req_in.dest;
            zero_register_op     : res = req_in.dest ^ req_in.dest;
            ones_complement_op :
            begin
               res          = ALL_ONES - req_in.dest;
               calc[FLAG_C] = 1'b1;
               upd          = 8'h1f;
            end
            all_ones_register_op :
            begin
               res = ALL_ONES;
               upd = 8'h00;
            end
            default :
            begin
               write_res = 1'b0;
               upd       = 8'h00;
            end
         endcase
      end
      // signed overflow of a single step is fixed by the result alone
      if (req_in.op == increment_op)
         calc[FLAG_V] = (res == SIGNED_MIN);
      if (req_in.op == decrement_op)
         calc[FLAG_V] = (res == SIGNED_MAX);
      calc[FLAG_Z] = (res == 8'h00);
      calc[FLAG_N] = res[7];
      calc[FLAG_S] = calc[FLAG_N] ^ calc[FLAG_V];
   end

   // ****************************************************************
   // next state: flags, result and read-modify-write sequencer
   // ****************************************************************
   always_comb
   begin
      // alu update wins over a software write in the same cycle
      base               = sfr_wr ? io_wdata_in : flags_reg;
      flags_next         = base;
      result_next        = result_reg;
      result_valid_next  = 1'b0;
      state_next         = state_reg;
      busy_next          = busy_reg;
      io_rd_next         = 1'b0;
      io_addr_next       = io_addr_reg;
      bit_next           = bit_reg;
      set_next           = set_reg;
      io_wr_next         = 1'b0;
      io_wdata_next      = io_wdata_reg;
      refused_next       = 1'b0;
      case (state_reg)
         st_idle :
         begin
            if (take & is_bit_op)
            begin
               if (req_in.io_addr <= BIT_OP_ADDR_MAX)
               begin
                  state_next   = st_rmw;
                  busy_next    = 1'b1;
                  io_rd_next   = 1'b1;
                  io_addr_next = req_in.io_addr;
                  bit_next     = req_in.io_bit;
                  set_next     = (req_in.op == io_bit_set_op);
               end
               else
                  refused_next = 1'b1;
            end
            else if (take & write_res)
            begin
               result_next       = res;
               result_valid_next = 1'b1;
               flags_next        = (base & ~upd) | (calc & upd);
            end
         end
         st_rmw :
         begin
            // whole register is written back; flags read as one are cleared by that one
            io_wr_next    = 1'b1;
            // zero in a clear-on-one flag leaves it untouched at the peripheral
            io_wdata_next = set_reg ? (io_rdata_in | (8'h01 << bit_reg))
                                    : (io_rdata_in & ~(8'h01 << bit_reg));
            state_next    = st_idle;
            busy_next     = 1'b0;
         end
         default :
         begin
            state_next = st_idle;
            busy_next  = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         result_reg       <= 8'h00;
         result_valid_reg <= 1'b0;
         flags_reg        <= STATUS_FLAGS_RESET;
         state_reg        <= st_idle;
         busy_reg         <= 1'b0;
         io_rd_reg        <= 1'b0;
         io_addr_reg      <= 6'h00;
         bit_reg          <= 3'h0;
         set_reg          <= 1'b0;
         io_wr_reg        <= 1'b0;
         io_wdata_reg     <= 8'h00;
         refused_reg      <= 1'b0;
      end
      else
      begin
         result_reg       <= result_next;
         result_valid_reg <= result_valid_next;
         flags_reg        <= flags_next;
         state_reg        <= state_next;
         busy_reg         <= busy_next;
         io_rd_reg        <= io_rd_next;
         io_addr_reg      <= io_addr_next;
         bit_reg          <= bit_next;
         set_reg          <= set_next;
         io_wr_reg        <= io_wr_next;
         io_wdata_reg     <= io_wdata_next;
         refused_reg      <= refused_next;
      end
   end

   assign result_out                 = result_reg;
   assign result_valid_out           = result_valid_reg;
   assign processor_status_flags_out = flags_reg;
   assign busy_out                   = busy_reg;
   assign io_rd_out                  = io_rd_reg;
   assign io_addr_out                = io_addr_reg;
   assign io_wr_out                  = io_wr_reg;
   assign io_wdata_out               = io_wdata_reg;
   assign bit_op_refused_out         = refused_reg;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   chk_add_result: assert property (
      take && req_in.op == add_op |=> result_valid_out && result_out == 8'($past(req_in.dest) + $past(req_in.src)))
      else $error("add result wrong");
   chk_sub_carry: assert property (
      take && req_in.op == subtract_op && !sfr_wr |=> flags_reg[FLAG_C] == ($past(req_in.src) > $past(req_in.dest)))
      else $error("subtract carry wrong");
   chk_imm_sub_zero: assert property (
      take && req_in.op == subtract_immediate_op && !sfr_wr |=> flags_reg[FLAG_Z] == ($past(req_in.dest) == $past(req_in.imm)))
      else $error("subtract immediate zero wrong");
   chk_imm_borrow_result: assert property (
      take && req_in.op == subtract_carry_immediate_op
      |=> result_out == 8'($past(req_in.dest) - $past(req_in.imm) - {7'h00, $past(flags_reg[FLAG_C])}))
      else $error("subtract carry immediate wrong");
   chk_and_keeps_ch: assert property (
      take && (req_in.op == and_op || req_in.op == and_immediate_op) && !sfr_wr
      |=> $stable({flags_reg[FLAG_H], flags_reg[FLAG_C]}) && !flags_reg[FLAG_V])
      else $error("logic op touched carry");
   chk_clear_mask: assert property (
      take && req_in.op == clear_mask_bits_op |=> (result_out & $past(req_in.imm)) == 8'h00)
      else $error("masked bits not cleared");
   chk_rmw_write: assert property (
      take && is_bit_op && req_in.io_addr <= BIT_OP_ADDR_MAX |=> io_rd_out && busy_out ##1 io_wr_out && !busy_out)
      else $error("bit op sequence wrong");
   chk_bit_refused: assert property (
      take && is_bit_op && req_in.io_addr > BIT_OP_ADDR_MAX |=> bit_op_refused_out && !io_rd_out ##1 !io_wr_out)
      else $error("high address bit op not refused");
   chk_invert_carry: assert property (
      take && req_in.op == ones_complement_op && !sfr_wr |=> flags_reg[FLAG_C] && result_out == ~$past(req_in.dest))
      else $error("complement wrong");
   chk_ones_flags: assert property (
      take && req_in.op == all_ones_register_op && !sfr_wr |=> $stable(flags_reg) && result_out == ALL_ONES)
      else $error("load ones touched flags");

endmodule

`default_nettype wire

// [core/alu_flag_pkg.sv]
package alu_flag_pkg;

   // ****************************************************************
   // status register location and bit layout
   // ****************************************************************
   localparam logic [5:0] STATUS_FLAGS_ADDR  = 6'h3f;
   localparam logic [7:0] STATUS_FLAGS_RESET = 8'h00;
   localparam int         FLAG_C             = 0;
   localparam int         FLAG_Z             = 1;
   localparam int         FLAG_N             = 2;
   localparam int         FLAG_V             = 3;
   localparam int         FLAG_S             = 4;
   localparam int         FLAG_H             = 5;
   localparam int         FLAG_T             = 6;
   localparam int         FLAG_I             = 7;

   // ****************************************************************
   // constants and timing
   // ****************************************************************
   localparam logic [5:0] BIT_OP_ADDR_MAX = 6'h1f;
   localparam logic [7:0] ALL_ONES        = 8'hff;
   localparam logic [7:0] SIGNED_MIN      = 8'h80;
   localparam logic [7:0] SIGNED_MAX      = 8'h7f;
   localparam int         ALU_CYCLES      = 1;
   localparam int         BIT_OP_CYCLES   = 2;

   // ****************************************************************
   // operations and carriers
   // ****************************************************************
   typedef enum logic [4:0] {
      add_op, add_carry_op, subtract_op, subtract_with_carry_op,
      subtract_immediate_op, subtract_carry_immediate_op,
      and_op, and_immediate_op, or_op, or_immediate_op, exclusive_or_op,
      ones_complement_op, twos_complement_op, set_mask_bits_op,
      clear_mask_bits_op, increment_op, decrement_op, zero_minus_test_op,
      zero_register_op, all_ones_register_op, io_bit_set_op, io_bit_clear_op
   } op_code_type;

   typedef struct packed {
      op_code_type op;
      logic [7:0]  dest;
      logic [7:0]  src;
      logic [7:0]  imm;
      logic [5:0]  io_addr;
      logic [2:0]  io_bit;
   } alu_req_type;

   typedef enum logic [1:0] {
      st_idle = 2'b01,
      st_rmw  = 2'b10
   } rmw_state_type;

endpackage

// [dv/io_space_model.sv]
`timescale 1ns/1ps
`default_nettype none

module io_space_model
   import alu_flag_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rd_in,
   input  wire logic [5:0] addr_in,
   input  wire logic       wr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       preset_in,
   input  wire logic [5:0] preset_addr_in,
   input  wire logic [7:0] preset_data_in,
   output logic [7:0]      rdata_out
);
   // ****************************************************************
   // lower I/O space with one flag register
   // ****************************************************************
   // flag register whose flags in bits 7, 6 and 4 clear on a written one
   localparam logic [5:0] FLAG_REG_ADDR = 6'h05;
   localparam logic [7:0] CLEAR_ON_ONE  = 8'hd0;
   logic [7:0]            mem [0:31]; // bit ops reach only the lower space

   // bench preset wins, else take the write-back of a bit op
   always_ff @(posedge clk_in)
   begin
      if (preset_in)
         mem[preset_addr_in[4:0]] <= preset_data_in;
      else if (wr_in && addr_in == FLAG_REG_ADDR)
         mem[addr_in[4:0]] <= (wdata_in & ~CLEAR_ON_ONE) | (mem[addr_in[4:0]] & CLEAR_ON_ONE & ~wdata_in);
      else if (wr_in)
         mem[addr_in[4:0]] <= wdata_in;
   end

   // outside a read the bus shows the inverse, so a late sample cannot match by luck
   assign rdata_out = rd_in ? mem[addr_in[4:0]] : ~mem[addr_in[4:0]];
endmodule

`default_nettype wire

// [dv/alu_flag_datapath_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module alu_flag_datapath_bench
   import alu_flag_pkg::*;
;
   logic        clk_in, srst_in, req_valid_in, io_wr_in, preset;
   alu_req_type req_in;
   logic [5:0]  io_waddr_in, preset_addr, io_addr;
   logic [7:0]  io_wdata_in, preset_data, io_rdata, result, flags, io_wdata, exp_f;
   logic        result_valid, busy, io_rd, io_wr, refused;
   int          mismatches, num_checks;

   alu_flag_datapath dut (.clk_in(clk_in), .srst_in(srst_in), .req_valid_in(req_valid_in), .req_in(req_in),
      .io_wr_in(io_wr_in), .io_waddr_in(io_waddr_in), .io_wdata_in(io_wdata_in), .io_rdata_in(io_rdata),
      .result_out(result), .result_valid_out(result_valid), .processor_status_flags_out(flags),
      .busy_out(busy), .io_rd_out(io_rd), .io_addr_out(io_addr), .io_wr_out(io_wr),
      .io_wdata_out(io_wdata), .bit_op_refused_out(refused));

   io_space_model io (.clk_in(clk_in), .rd_in(io_rd), .addr_in(io_addr), .wr_in(io_wr), .wdata_in(io_wdata),
      .preset_in(preset), .preset_addr_in(preset_addr), .preset_data_in(preset_data), .rdata_out(io_rdata));

   // 50 MHz core clock
   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   // ****************************************************************
   // reference and helpers
   // ****************************************************************
   // expected {flags, result}; kept apart from the design on purpose
   function automatic logic [15:0] ref_alu(input alu_req_type q, input logic [7:0] f);
      logic [7:0] a, b, r, n;
      logic [8:0] w;
      logic [4:0] h;
      logic       ci;
      n = f;
      a = (q.op == twos_complement_op) ? 8'h00 : q.dest;
      b = (q.op inside {subtract_immediate_op, subtract_carry_immediate_op, and_immediate_op, or_immediate_op,
           set_mask_bits_op, clear_mask_bits_op}) ? q.imm : q.src;
      b = (q.op == twos_complement_op) ? q.dest : b;
      ci = (q.op inside {add_carry_op, subtract_with_carry_op, subtract_carry_immediate_op}) & f[FLAG_C];
      n[FLAG_V] = 1'b0;
      w = {1'b0, a} - {1'b0, b} - {8'h00, ci};
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
      if (q.op inside {add_op, add_carry_op})
      begin
         w = {1'b0, a} + {1'b0, b} + {8'h00, ci};
         h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      end
      case (q.op)
         and_op, and_immediate_op: r = a & b;
         or_op, or_immediate_op, set_mask_bits_op: r = a | b;
         clear_mask_bits_op: r = a & (ALL_ONES - b);
         exclusive_or_op: r = a ^ b;
         zero_minus_test_op: r = a & a;
         zero_register_op: r = a ^ a;
         ones_complement_op: r = ALL_ONES - a;
         increment_op: r = a + 8'h01;
         decrement_op: r = a - 8'h01;
         all_ones_register_op: return {f, ALL_ONES};
         default: r = w[7:0];
      endcase
      if (q.op inside {add_op, add_carry_op})
         n[FLAG_V] = (a[7] == b[7]) && (r[7] != a[7]);
      else if (q.op inside {subtract_op, subtract_with_carry_op, subtract_immediate_op,
               subtract_carry_immediate_op, twos_complement_op})
         n[FLAG_V] = (a[7] != b[7]) && (r[7] != a[7]);
      if (q.op inside {add_op, add_carry_op, subtract_op, subtract_with_carry_op, subtract_immediate_op,
          subtract_carry_immediate_op, twos_complement_op})
      begin
         n[FLAG_C] = w[8];
         n[FLAG_H] = h[4];
      end
      n[FLAG_V] = (q.op == increment_op) ? (r == SIGNED_MIN) : (q.op == decrement_op) ? (r == SIGNED_MAX) : n[FLAG_V];
      n[FLAG_C] = (q.op == ones_complement_op) ? 1'b1 : n[FLAG_C];
      n[FLAG_Z] = (r == 8'h00);
      n[FLAG_N] = r[7];
      n[FLAG_S] = n[FLAG_N] ^ n[FLAG_V];
      return {n, r};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      if (mismatches == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic write_status(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_in);
      io_wr_in <= 1'b1;
      io_waddr_in <= a;
      io_wdata_in <= d;
      @(posedge clk_in);
      io_wr_in <= 1'b0;
      #1;
      exp_f = (a == STATUS_FLAGS_ADDR) ? d : exp_f;
      check({8'h00, flags}, {8'h00, exp_f});
   endtask

   // every ALU op back to back, flags chained from one op to the next
   task automatic test_alu_chain(input logic [7:0] f0, input logic [7:0] d, input logic [7:0] s, input logic [7:0] k);
      alu_req_type q, prev;
      logic [15:0] e;
      write_status(STATUS_FLAGS_ADDR, f0);
      prev = '0;
      for (int i = 0; i <= 20; i++)
      begin
         @(posedge clk_in);
         q = '0;
         q.op = op_code_type'(i[4:0]);
         q.dest = d;
         q.src = s;
         q.imm = k;
         req_valid_in <= (i < 20);
         req_in <= q;
         #1;
         if (i > 0)
         begin
            e = ref_alu(prev, exp_f);
            exp_f = e[15:8];
            check({result_valid, 7'h00, result}, {8'h80, e[7:0]});
            check({8'h00, flags}, {8'h00, exp_f});
         end
         prev = q;
      end
      @(posedge clk_in);
      #1;
      check({15'h0000, result_valid}, 16'h0000);
   endtask

   // read-modify-write of a whole I/O register, with an ALU request pushed while busy
   task automatic test_bit_op(input op_code_type op, input logic [5:0] a, input logic [2:0] b,
                              input logic [7:0] v, input logic [7:0] after);
      alu_req_type q;
      logic [7:0]  wexp;
      q = '0;
      q.op = op;
      q.io_addr = a;
      q.io_bit = b;
      q.dest = 8'h01;
      wexp = (op == io_bit_set_op) ? (v | (8'h01 << b)) : (v & ~(8'h01 << b));
      @(posedge clk_in);
      preset <= 1'b1;
      preset_addr <= a;
      preset_data <= v;
      @(posedge clk_in);
      preset <= 1'b0;
      req_valid_in <= 1'b1;
      req_in <= q;
      @(posedge clk_in);
      q.op = add_op;
      req_in <= q;
      req_valid_in <= (a <= BIT_OP_ADDR_MAX);
      #1;
      if (a > BIT_OP_ADDR_MAX)
      begin
         check({14'h0000, refused, io_rd}, 16'h0002);
         @(posedge clk_in);
         #1;
         check({14'h0000, io_rd, io_wr}, 16'h0000);
      end
      else
      begin
         check({5'h00, refused, io_rd, busy, 2'b00, io_addr}, {8'h03, 2'b00, a});
         @(posedge clk_in);
         req_valid_in <= 1'b0;
         #1;
         check({result_valid, io_wr, 6'h00, io_wdata}, {8'h40, wexp});
         @(posedge clk_in);
         #1;
         check({8'h00, io.mem[a[4:0]]}, {8'h00, after});
      end
   endtask

   // ****************************************************************
   // main sequence and watchdog
   // ****************************************************************
   initial
   begin
      srst_in = 1'b1;
      req_valid_in = 1'b0;
      req_in = '0;
      io_wr_in = 1'b0;
      io_waddr_in = 6'h00;
      io_wdata_in = 8'h00;
      preset = 1'b0;
      preset_addr = 6'h00;
      preset_data = 8'h00;
      mismatches = 0;
      num_checks = 0;
      exp_f = STATUS_FLAGS_RESET;
      repeat (4) @(posedge clk_in);
      srst_in <= 1'b0;
      @(posedge clk_in);
      #1;
      check({result, flags}, {8'h00, STATUS_FLAGS_RESET});
      check({11'h000, result_valid, busy, io_rd, io_wr, refused}, 16'h0000);
      write_status(STATUS_FLAGS_ADDR, 8'h81);
      write_status(6'h12, 8'h5a);
      test_alu_chain(8'h21, 8'h7f, 8'h01, 8'h80);
      test_alu_chain(8'h00, 8'h00, 8'hff, 8'h01);
      test_alu_chain(8'hff, 8'h80, 8'h80, 8'h0f);
      test_alu_chain(8'h21, 8'h0f, 8'h01, 8'hf0);
      test_bit_op(io_bit_set_op, 6'h05, 3'd2, 8'hd0, 8'h04);
      test_bit_op(io_bit_clear_op, 6'h05, 3'd7, 8'h94, 8'h84);
      test_bit_op(io_bit_set_op, 6'h1b, 3'd0, 8'h06, 8'h07);
      test_bit_op(io_bit_clear_op, 6'h20, 3'd1, 8'h00, 8'h00);
      conclude;
   end

   // the whole run needs about 125 cycles
   initial
   begin
      repeat (3000) @(posedge clk_in);
      mismatches++;
      conclude;
   end
endmodule

`default_nettype wire
